// ---- rtl/pirqf_pkg.sv ----
package pirqf_pkg;
   // ----------------------------------------------------------------------
   // register map (byte addresses on the wishbone bus)
   // ----------------------------------------------------------------------
   localparam logic [7:0] PIRQF_FLAGS_ADDR = 8'h0C;
   localparam logic [7:0] PIRQF_ENABLES_ADDR = 8'h8C;
   localparam logic [7:0] PIRQF_CTRL_ADDR = 8'h10;
   localparam logic [7:0] PIRQF_STATUS_ADDR = 8'h14;
   localparam logic [7:0] PIRQF_MASK_ADDR = 8'h18;

   // ----------------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------------
   localparam int PIRQF_BIT_NVW = 7;
   localparam int PIRQF_BIT_CMP = 6;
   localparam int PIRQF_BIT_RX = 5;
   localparam int PIRQF_BIT_TX = 4;
   localparam int PIRQF_BIT_CCP = 2;
   localparam int PIRQF_BIT_TB = 1;
   localparam int PIRQF_BIT_TA = 0;
   localparam int PIRQF_CTRL_GLOBAL = 0;
   localparam int PIRQF_CTRL_PGATE = 1;
   localparam int PIRQF_STAT_PREQ = 0;
   localparam int PIRQF_STAT_CPU = 1;

   // writable flag bits, implemented enable bits
   localparam logic [7:0] PIRQF_FLAG_WMASK = 8'hC7;
   localparam logic [7:0] PIRQF_EN_MASK = 8'hF7;
   localparam logic [7:0] PIRQF_RESET_VAL = 8'h00;
   localparam logic [1:0] PIRQF_CTRL_RESET = 2'h0;
   localparam logic [1:0] PIRQF_STAT_RESET = 2'h0;

   // capture/compare unit modes
   typedef enum logic [1:0]
   {
      PIRQF_MODE_OFF = 2'h0,
      PIRQF_MODE_CAPTURE = 2'h1,
      PIRQF_MODE_COMPARE = 2'h3,
      PIRQF_MODE_PWM = 2'h2
   } pirqf_ccp_mode_t;
endpackage

// ---- rtl/pirqf_core.sv ----
`timescale 1ns/1ps
module pirqf_core
   import pirqf_pkg::*;
(
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   output logic wb_ack_o,
   input wire logic nv_write_done,
   input wire logic comparator_out,
   input wire logic serial_rx_full,
   input wire logic serial_tx_empty,
   input wire logic [1:0] capcmp_mode,
   input wire logic capcmp_capture,
   input wire logic capcmp_match,
   input wire logic timer_b_match,
   input wire logic timer_a_overflow,
   output logic peripheral_irq_req,
   output logic cpu_irq,
   output logic irq_o
);

   // ----------------------------------------------------------------------
   // pin input synchronisers
   // ----------------------------------------------------------------------
   // comparator output is asynchronous; others come from core-clock logic
   logic [2:0] cmp_sync_q;
   logic cmp_stable_q;
   logic cmp_change;

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         cmp_sync_q <= 3'h0;
      else
         cmp_sync_q <= {cmp_sync_q[1:0], comparator_out};
   end

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         cmp_stable_q <= 1'b0;
      else if (cmp_sync_q[1] == cmp_sync_q[2])
         cmp_stable_q <= cmp_sync_q[2];
   end

   // stable level resets to zero; a comparator already high at reset release flags an event
   assign cmp_change = (cmp_sync_q[1] == cmp_sync_q[2]) && (cmp_sync_q[2] != cmp_stable_q);

   // ----------------------------------------------------------------------
   // wishbone slave
   // ----------------------------------------------------------------------
   logic bus_req;
   logic wr_lo;
   logic rd_req;
   logic [7:0] flags_q;
   logic [7:0] enables_q;
   logic [1:0] ctrl_q;
   logic [7:0] status_q;
   logic [7:0] mask_q;
   logic [7:0] flag_view;
   logic [7:0] rd_data;
   pirqf_ccp_mode_t ccp_mode;

   assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr_lo = bus_req && wb_we_i && wb_sel_i[0];
   assign rd_req = bus_req && !wb_we_i;
   assign ccp_mode = pirqf_ccp_mode_t'(capcmp_mode);

   // serial bits mirror live buffer state, bit 3 is tied low
   always_comb
   begin
      flag_view = flags_q & PIRQF_FLAG_WMASK;
      flag_view[PIRQF_BIT_RX] = serial_rx_full;
      flag_view[PIRQF_BIT_TX] = serial_tx_empty;
   end

   always_comb
   begin
      case (wb_adr_i)
         PIRQF_FLAGS_ADDR: rd_data = flag_view;
         PIRQF_ENABLES_ADDR: rd_data = enables_q & PIRQF_EN_MASK;
         PIRQF_CTRL_ADDR: rd_data = {6'h00, ctrl_q};
         PIRQF_STATUS_ADDR: rd_data = status_q;
         PIRQF_MASK_ADDR: rd_data = mask_q;
         default: rd_data = 8'h00;
      endcase
   end

   // one-wait-state ack; unmapped addresses ack with zero data
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         wb_ack_o <= 1'b0;
      else
         wb_ack_o <= bus_req;
   end

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         wb_dat_o <= 32'h0000_0000;
      else if (rd_req)
         wb_dat_o <= {24'h00_0000, rd_data};
   end

   // ----------------------------------------------------------------------
   // flag register
   // ----------------------------------------------------------------------
   logic [7:0] flag_set;
   logic ccp_event;

   // pwm mode and off mode leave bit 2 alone
   always_comb
   begin
      case (ccp_mode)
         PIRQF_MODE_CAPTURE: ccp_event = capcmp_capture;
         PIRQF_MODE_COMPARE: ccp_event = capcmp_match;
         PIRQF_MODE_PWM: ccp_event = 1'b0;
         default: ccp_event = 1'b0;
      endcase
   end

   // set sources ignore every enable
   always_comb
   begin
      flag_set = 8'h00;
      flag_set[PIRQF_BIT_NVW] = nv_write_done;
      flag_set[PIRQF_BIT_CMP] = cmp_change;
      flag_set[PIRQF_BIT_CCP] = ccp_event;
      flag_set[PIRQF_BIT_TB] = timer_b_match;
      flag_set[PIRQF_BIT_TA] = timer_a_overflow;
   end

   // a set in the same cycle as a software clear wins
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         flags_q <= PIRQF_RESET_VAL;
      else if (wr_lo && wb_adr_i == PIRQF_FLAGS_ADDR)
         flags_q <= ((wb_dat_i[7:0] & PIRQF_FLAG_WMASK) | flag_set) & PIRQF_FLAG_WMASK;
      else
         flags_q <= (flags_q | flag_set) & PIRQF_FLAG_WMASK;
   end

   // ----------------------------------------------------------------------
   // enable and control registers
   // ----------------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         enables_q <= PIRQF_RESET_VAL;
      else if (wr_lo && wb_adr_i == PIRQF_ENABLES_ADDR)
         enables_q <= wb_dat_i[7:0] & PIRQF_EN_MASK;
   end

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         ctrl_q <= PIRQF_CTRL_RESET;
      else if (wr_lo && wb_adr_i == PIRQF_CTRL_ADDR)
         ctrl_q <= wb_dat_i[1:0];
   end

   // ----------------------------------------------------------------------
   // request forming
   // ----------------------------------------------------------------------
   logic [7:0] gated;
   logic preq_d;
   logic cpu_d;

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++)
      begin : g_gate
         assign gated[gi] = flag_view[gi] & enables_q[gi];
      end
   endgenerate

   assign preq_d = |gated;
   assign cpu_d = preq_d && ctrl_q[PIRQF_CTRL_PGATE] && ctrl_q[PIRQF_CTRL_GLOBAL];

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         peripheral_irq_req <= 1'b0;
      else
         peripheral_irq_req <= preq_d;
   end

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         cpu_irq <= 1'b0;
      else
         cpu_irq <= cpu_d;
   end

   // ----------------------------------------------------------------------
   // sticky status, mask, interrupt line
   // ----------------------------------------------------------------------
   logic [7:0] stat_set;

   always_comb
   begin
      stat_set = 8'h00;
      stat_set[PIRQF_STAT_PREQ] = preq_d && !peripheral_irq_req;
      stat_set[PIRQF_STAT_CPU] = cpu_d && !cpu_irq;
   end

   // read-to-clear; an edge in the read cycle stays set
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         status_q <= PIRQF_RESET_VAL;
      else if (rd_req && wb_adr_i == PIRQF_STATUS_ADDR)
         status_q <= stat_set;
      else
         status_q <= status_q | stat_set;
   end

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         mask_q <= PIRQF_RESET_VAL;
      else if (wr_lo && wb_adr_i == PIRQF_MASK_ADDR)
         mask_q <= wb_dat_i[7:0];
   end

   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
         irq_o <= 1'b0;
      else
         irq_o <= |((status_q | stat_set) & mask_q);
   end

   // ----------------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------------
   property p_flag_sets;
      @(posedge ref_clk) disable iff (!resetn)
      timer_a_overflow |=> flags_q[PIRQF_BIT_TA];
   endproperty
   a_flag_sets: assert property (p_flag_sets) else $error("overflow flag not set");

   property p_nvw_hold;
      @(posedge ref_clk) disable iff (!resetn)
      flags_q[PIRQF_BIT_NVW] && !(wr_lo && wb_adr_i == PIRQF_FLAGS_ADDR)
         |=> flags_q[PIRQF_BIT_NVW];
   endproperty
   a_nvw_hold: assert property (p_nvw_hold) else $error("write-done flag dropped");

   property p_tb_set;
      @(posedge ref_clk) disable iff (!resetn)
      timer_b_match |=> flags_q[PIRQF_BIT_TB];
   endproperty
   a_tb_set: assert property (p_tb_set) else $error("period flag not set");

   property p_cmp_edge;
      @(posedge ref_clk) disable iff (!resetn)
      $changed(cmp_stable_q) |-> flags_q[PIRQF_BIT_CMP];
   endproperty
   a_cmp_edge: assert property (p_cmp_edge) else $error("comparator flag missed");

   property p_rx_view;
      @(posedge ref_clk) disable iff (!resetn)
      rd_req && wb_adr_i == PIRQF_FLAGS_ADDR
         |=> wb_dat_o[PIRQF_BIT_RX] == $past(serial_rx_full)
         && (wb_dat_o[7:0] & ~PIRQF_EN_MASK) == 8'h00;
   endproperty
   a_rx_view: assert property (p_rx_view) else $error("flag read wrong");

   property p_pwm_quiet;
      @(posedge ref_clk) disable iff (!resetn)
      ccp_mode == PIRQF_MODE_PWM && !flags_q[PIRQF_BIT_CCP]
         && !(wr_lo && wb_adr_i == PIRQF_FLAGS_ADDR) |=> !flags_q[PIRQF_BIT_CCP];
   endproperty
   a_pwm_quiet: assert property (p_pwm_quiet) else $error("pwm set bit 2");

   // judged from flags and enables directly, so a broken gate loop shows
   property p_req_on;
      @(posedge ref_clk) disable iff (!resetn)
      |(flag_view & enables_q) |=> peripheral_irq_req;
   endproperty
   a_req_on: assert property (p_req_on) else $error("request missing");

   property p_req_off;
      @(posedge ref_clk) disable iff (!resetn)
      !(|(flag_view & enables_q)) |=> !peripheral_irq_req;
   endproperty
   a_req_off: assert property (p_req_off) else $error("request without source");

   property p_global_mask;
      @(posedge ref_clk) disable iff (!resetn)
      !ctrl_q[PIRQF_CTRL_GLOBAL] |=> !cpu_irq;
   endproperty
   a_global_mask: assert property (p_global_mask) else $error("irq while disabled");

   property p_pgate_mask;
      @(posedge ref_clk) disable iff (!resetn)
      !ctrl_q[PIRQF_CTRL_PGATE] |=> !cpu_irq;
   endproperty
   a_pgate_mask: assert property (p_pgate_mask) else $error("irq while gated");

   property p_en_bit3;
      @(posedge ref_clk) disable iff (!resetn)
      (enables_q & ~PIRQF_EN_MASK) == 8'h00 && (flags_q & ~PIRQF_FLAG_WMASK) == 8'h00;
   endproperty
   a_en_bit3: assert property (p_en_bit3) else $error("bit 3 set");

   property p_nvw_set;
      @(posedge ref_clk) disable iff (!resetn)
      nv_write_done |=> flags_q[PIRQF_BIT_NVW];
   endproperty
   a_nvw_set: assert property (p_nvw_set) else $error("write-done flag not set");

   property p_capture_set;
      @(posedge ref_clk) disable iff (!resetn)
      ccp_mode == PIRQF_MODE_CAPTURE && capcmp_capture |=> flags_q[PIRQF_BIT_CCP];
   endproperty
   a_capture_set: assert property (p_capture_set) else $error("capture flag not set");

   property p_compare_set;
      @(posedge ref_clk) disable iff (!resetn)
      ccp_mode == PIRQF_MODE_COMPARE && capcmp_match |=> flags_q[PIRQF_BIT_CCP];
   endproperty
   a_compare_set: assert property (p_compare_set) else $error("match flag not set");

   property p_tx_view;
      @(posedge ref_clk) disable iff (!resetn)
      rd_req && wb_adr_i == PIRQF_FLAGS_ADDR
         |=> wb_dat_o[PIRQF_BIT_TX] == $past(serial_tx_empty);
   endproperty
   a_tx_view: assert property (p_tx_view) else $error("transmit bit read wrong");

   property p_rx_gate;
      @(posedge ref_clk) disable iff (!resetn)
      enables_q[PIRQF_BIT_RX] && serial_rx_full |=> peripheral_irq_req;
   endproperty
   a_rx_gate: assert property (p_rx_gate) else $error("receive request missing");

   property p_tx_gate;
      @(posedge ref_clk) disable iff (!resetn)
      enables_q[PIRQF_BIT_TX] && serial_tx_empty |=> peripheral_irq_req;
   endproperty
   a_tx_gate: assert property (p_tx_gate) else $error("transmit request missing");

   property p_flag_clear;
      @(posedge ref_clk) disable iff (!resetn)
      wr_lo && wb_adr_i == PIRQF_FLAGS_ADDR && !wb_dat_i[PIRQF_BIT_TA] && !timer_a_overflow
         |=> !flags_q[PIRQF_BIT_TA];
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("overflow flag not cleared");

endmodule

// ---- sim/pirqf_src_model.sv ----
`timescale 1ns/1ps
// ----------------------------------------------
// event sources beside the flag block
// ----------------------------------------------
module pirqf_src_model
(
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic [7:0] req,
   output logic nv_write_done,
   output logic comparator_out,
   output logic capcmp_capture,
   output logic capcmp_match,
   output logic timer_b_match,
   output logic timer_a_overflow
);
   // single-cycle pulses; comparator only toggles its level
   always_ff @(posedge ref_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         nv_write_done <= 1'b0;
         comparator_out <= 1'b0;
         capcmp_capture <= 1'b0;
         capcmp_match <= 1'b0;
         timer_b_match <= 1'b0;
         timer_a_overflow <= 1'b0;
      end
      else
      begin
         nv_write_done <= req[7];
         comparator_out <= comparator_out ^ req[6];
         capcmp_capture <= req[2];
         capcmp_match <= req[3];
         timer_b_match <= req[1];
         timer_a_overflow <= req[0];
      end
   end
endmodule

// ---- sim/tb_peripheral_irq_enable_flag.sv ----
`timescale 1ns/1ps
module tb_peripheral_irq_enable_flag
   import pirqf_pkg::*;
;
   logic ref_clk, resetn, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, peripheral_irq_req;
   logic nv_write_done, comparator_out, serial_rx_full, serial_tx_empty, cpu_irq, irq_o;
   logic capcmp_capture, capcmp_match, timer_b_match, timer_a_overflow;
   logic [7:0] wb_adr_i, req, rd;
   logic [31:0] wb_dat_i, wb_dat_o;
   logic [3:0] wb_sel_i;
   logic [1:0] capcmp_mode;
   int num_errors = 0;
   int total_checks = 0;
   int cycles = 0;

   pirqf_core u_pirqf_core (.ref_clk(ref_clk), .resetn(resetn), .wb_adr_i(wb_adr_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i),
      .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
      .nv_write_done(nv_write_done), .comparator_out(comparator_out),
      .serial_rx_full(serial_rx_full), .serial_tx_empty(serial_tx_empty),
      .capcmp_mode(capcmp_mode), .capcmp_capture(capcmp_capture),
      .capcmp_match(capcmp_match), .timer_b_match(timer_b_match),
      .timer_a_overflow(timer_a_overflow), .peripheral_irq_req(peripheral_irq_req),
      .cpu_irq(cpu_irq), .irq_o(irq_o));

   pirqf_src_model u_pirqf_src_model (.ref_clk(ref_clk), .resetn(resetn), .req(req),
      .nv_write_done(nv_write_done), .comparator_out(comparator_out),
      .capcmp_capture(capcmp_capture), .capcmp_match(capcmp_match),
      .timer_b_match(timer_b_match), .timer_a_overflow(timer_a_overflow));

   initial
   begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   // ----------------------------------------------
   // bus, checks, report
   // ----------------------------------------------
   task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d,
      input logic [3:0] s);
      @(posedge ref_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= {24'h000000, d};
      wb_sel_i <= s;
      @(posedge ref_clk);
      // wait is bounded by the global cycle ceiling
      while (wb_ack_o !== 1'b1)
         @(posedge ref_clk);
      rd = wb_dat_o[7:0];
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask

   task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("BAD t=%0t reg got %h exp %h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      total_checks++;
      if (got !== exp)
      begin
         num_errors++;
         $display("BAD t=%0t bit got %b exp %b", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      wb(1'b1, a, d, 4'hF);
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
      wb(1'b0, a, 8'h00, 4'hF);
      chk_reg(rd, e);
   endtask

   // comparator path needs several cycles through its synchroniser
   task automatic fire(input logic [7:0] r, input logic [1:0] m);
      @(posedge ref_clk);
      req <= r;
      capcmp_mode <= m;
      @(posedge ref_clk);
      req <= 8'h00;
      repeat (6) @(posedge ref_clk);
   endtask

   task automatic settle();
      repeat (3) @(posedge ref_clk);
   endtask

   task automatic test_done();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         num_errors++;
         $display("BAD t=%0t timeout", $time);
         test_done();
      end
   end

   // ----------------------------------------------
   // scenarios
   // ----------------------------------------------
   task automatic t_regs();
      rdchk(PIRQF_FLAGS_ADDR, 8'h00);
      rdchk(PIRQF_ENABLES_ADDR, 8'h00);
      wr(PIRQF_ENABLES_ADDR, 8'hFF);
      rdchk(PIRQF_ENABLES_ADDR, 8'hF7);
      wb(1'b1, PIRQF_ENABLES_ADDR, 8'h00, 4'hE);
      rdchk(PIRQF_ENABLES_ADDR, 8'hF7);
      wr(PIRQF_ENABLES_ADDR, 8'h00);
      wr(8'h40, 8'hFF);
      rdchk(8'h40, 8'h00);
      $display("register test done");
   endtask

   task automatic t_events();
      fire(8'h01, PIRQF_MODE_OFF);
      rdchk(PIRQF_FLAGS_ADDR, 8'h01);
      fire(8'h02, PIRQF_MODE_OFF);
      rdchk(PIRQF_FLAGS_ADDR, 8'h03);
      fire(8'h80, PIRQF_MODE_OFF);
      rdchk(PIRQF_FLAGS_ADDR, 8'h83);
      fire(8'h40, PIRQF_MODE_OFF);
      rdchk(PIRQF_FLAGS_ADDR, 8'hC3);
      fire(8'h04, PIRQF_MODE_CAPTURE);
      rdchk(PIRQF_FLAGS_ADDR, 8'hC7);
      chk_bit(peripheral_irq_req, 1'b0);
      wr(PIRQF_FLAGS_ADDR, 8'hC3);
      fire(8'h08, PIRQF_MODE_COMPARE);
      rdchk(PIRQF_FLAGS_ADDR, 8'hC7);
      wr(PIRQF_FLAGS_ADDR, 8'hC3);
      fire(8'h0C, PIRQF_MODE_PWM);
      rdchk(PIRQF_FLAGS_ADDR, 8'hC3);
      wr(PIRQF_FLAGS_ADDR, 8'h00);
      rdchk(PIRQF_FLAGS_ADDR, 8'h00);
      fire(8'h40, PIRQF_MODE_OFF);
      rdchk(PIRQF_FLAGS_ADDR, 8'h40);
      wr(PIRQF_FLAGS_ADDR, 8'h00);
      $display("event test done");
   endtask

   task automatic t_serial();
      @(posedge ref_clk);
      serial_rx_full <= 1'b1;
      serial_tx_empty <= 1'b0;
      settle();
      rdchk(PIRQF_FLAGS_ADDR, 8'h20);
      wr(PIRQF_FLAGS_ADDR, 8'hFF);
      rdchk(PIRQF_FLAGS_ADDR, 8'hE7);
      @(posedge ref_clk);
      serial_rx_full <= 1'b0;
      serial_tx_empty <= 1'b1;
      wr(PIRQF_FLAGS_ADDR, 8'h00);
      rdchk(PIRQF_FLAGS_ADDR, 8'h10);
      $display("serial test done");
   endtask

   task automatic t_irq();
      wr(PIRQF_ENABLES_ADDR, 8'h01);
      fire(8'h01, PIRQF_MODE_OFF);
      chk_bit(peripheral_irq_req, 1'b1);
      chk_bit(cpu_irq, 1'b0);
      wr(PIRQF_CTRL_ADDR, 8'h03);
      settle();
      chk_bit(cpu_irq, 1'b1);
      wr(PIRQF_CTRL_ADDR, 8'h02);
      settle();
      chk_bit(cpu_irq, 1'b0);
      wr(PIRQF_ENABLES_ADDR, 8'h00);
      settle();
      chk_bit(peripheral_irq_req, 1'b0);
      wr(PIRQF_FLAGS_ADDR, 8'h00);
      serial_rx_full <= 1'b1;
      wr(PIRQF_ENABLES_ADDR, 8'h20);
      settle();
      chk_bit(peripheral_irq_req, 1'b1);
      wr(PIRQF_ENABLES_ADDR, 8'h00);
      settle();
      chk_bit(peripheral_irq_req, 1'b0);
      chk_bit(irq_o, 1'b0);
      wr(PIRQF_MASK_ADDR, 8'h01);
      settle();
      chk_bit(irq_o, 1'b1);
      rdchk(PIRQF_STATUS_ADDR, 8'h03);
      settle();
      chk_bit(irq_o, 1'b0);
      rdchk(PIRQF_STATUS_ADDR, 8'h00);
      $display("interrupt test done");
   endtask

   // mid-run reset after registers hold ones; serial bits stay live
   task automatic t_reset();
      wr(PIRQF_ENABLES_ADDR, 8'hFF);
      wr(PIRQF_FLAGS_ADDR, 8'hC7);
      wr(PIRQF_CTRL_ADDR, 8'h03);
      settle();
      chk_bit(cpu_irq, 1'b1);
      @(posedge ref_clk);
      resetn <= 1'b0;
      settle();
      chk_bit(peripheral_irq_req, 1'b0);
      chk_bit(cpu_irq, 1'b0);
      resetn <= 1'b1;
      rdchk(PIRQF_FLAGS_ADDR, 8'h30);
      rdchk(PIRQF_ENABLES_ADDR, 8'h00);
      $display("reset test done");
   endtask

   initial
   begin
      resetn = 1'b0;
      {wb_we_i, wb_cyc_i, wb_stb_i, serial_rx_full, serial_tx_empty} = 5'h00;
      wb_adr_i = 8'h00;
      wb_dat_i = 32'h00000000;
      wb_sel_i = 4'h0;
      req = 8'h00;
      capcmp_mode = PIRQF_MODE_OFF;
      repeat (10) @(posedge ref_clk);
      resetn <= 1'b1;
      t_regs();
      t_events();
      t_serial();
      t_irq();
      t_reset();
      test_done();
   end
endmodule
